// ==== logic/iof_line_ctrl.sv ====
// iof_line_ctrl: register file, input-change interrupt and pad control
// of a 32-line parallel I/O port.
// Assumes one core clock, synchronous pins and a strobe bus master that
// never issues a read and a write in the same cycle.
`default_nettype none
module iof_line_ctrl (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [31:0]           addr_i,
  input  wire iof_pkg::iof_word_type wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output var  logic [31:0]           rdata_o,
  output var  logic                  irq_o,
  input  wire iof_pkg::iof_word_type pin_i,
  input  wire iof_pkg::iof_word_type line_out_en_i,
  output var  iof_pkg::iof_word_type pin_o,
  output var  iof_pkg::iof_word_type pin_oe_o
);
  import iof_pkg::*;

  // All software-visible state of the core
  typedef struct packed {
    iof_word_type filt_en;
    iof_word_type out_level;
    iof_word_type owp;
    iof_word_type imask;
    iof_word_type istat;
    iof_word_type odrain;
    logic [31:0]  rdata;
    logic         wp_on;
    logic         irq;
  } iof_core_state_type;

  iof_core_state_type st_ff;
  iof_core_state_type nxt_st;
  logic [31:0]        rd_mux;
  logic               wr_open;

  iof_line_if lif ();

  // Input side: sampling, glitch filter, change detect
  iof_pin_sampler u_sampler (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (pin_i),
    .lif        (lif.smp)
  );

  // Output side: registered pad data and enables
  iof_pad_drive u_pad (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .lif        (lif.drv),
    .pin_o      (pin_o),
    .pin_oe_o   (pin_oe_o)
  );

  // Settings handed to the line logic
  assign lif.filt_en    = st_ff.filt_en;
  assign lif.out_level  = st_ff.out_level;
  assign lif.open_drain = st_ff.odrain;
  assign lif.out_en     = line_out_en_i;

  // Setup registers accept writes only with protection off
  assign wr_open = wr_i && !st_ff.wp_on;

  // Read mux; write-only and unmapped addresses read as zero
  always_comb begin
    rd_mux = RDATA_ZERO;
    case (addr_i)
      ADDR_FILT_STAT:  rd_mux = st_ff.filt_en;
      ADDR_OUT_STATE:  rd_mux = st_ff.out_level;
      ADDR_PIN_SAMPLE: rd_mux = lif.level;
      ADDR_IRQ_MASK:   rd_mux = st_ff.imask;
      ADDR_IRQ_STAT:   rd_mux = st_ff.istat;
      ADDR_ODRAIN_ST:  rd_mux = st_ff.odrain;
      ADDR_OWP_STAT:   rd_mux = st_ff.owp;
      ADDR_PROT_MODE:  rd_mux[WP_ON_BIT] = st_ff.wp_on;
      default:         rd_mux = RDATA_ZERO;
    endcase
  end

  // Next-state of every register
  always_comb begin
    nxt_st = st_ff;
    // Read data stand for exactly one cycle after the strobe
    nxt_st.rdata = rd_i ? rd_mux : RDATA_ZERO;
    if (wr_i) begin
      case (addr_i)
        ADDR_FILT_EN: begin
          if (wr_open) begin
            nxt_st.filt_en = st_ff.filt_en | wdata_i;
          end
        end
        ADDR_FILT_DIS: begin
          if (wr_open) begin
            nxt_st.filt_en = st_ff.filt_en & ~wdata_i;
          end
        end
        ADDR_OUT_SET: begin
          nxt_st.out_level = st_ff.out_level | wdata_i;
        end
        ADDR_OUT_CLR: begin
          nxt_st.out_level = st_ff.out_level & ~wdata_i;
        end
        ADDR_OUT_STATE: begin
          // Lines without permission keep their level
          nxt_st.out_level = (st_ff.out_level & ~st_ff.owp) |
                             (wdata_i & st_ff.owp);
        end
        ADDR_IRQ_EN: begin
          nxt_st.imask = st_ff.imask | wdata_i;
        end
        ADDR_IRQ_DIS: begin
          nxt_st.imask = st_ff.imask & ~wdata_i;
        end
        ADDR_ODRAIN_EN: begin
          if (wr_open) begin
            nxt_st.odrain = st_ff.odrain | wdata_i;
          end
        end
        ADDR_ODRAIN_DIS: begin
          if (wr_open) begin
            nxt_st.odrain = st_ff.odrain & ~wdata_i;
          end
        end
        ADDR_OWP_EN: begin
          if (wr_open) begin
            nxt_st.owp = st_ff.owp | wdata_i;
          end
        end
        ADDR_OWP_DIS: begin
          if (wr_open) begin
            nxt_st.owp = st_ff.owp & ~wdata_i;
          end
        end
        ADDR_PROT_MODE: begin
          // Always writable, or protection could never be lifted
          nxt_st.wp_on = wdata_i[WP_ON_BIT];
        end
        default: begin
          nxt_st.wp_on = st_ff.wp_on;
        end
      endcase
    end
    // Read clears the status; a change in the same cycle still lands,
    // so no event is lost between the read and the clear
    if (rd_i && (addr_i == ADDR_IRQ_STAT)) begin
      nxt_st.istat = lif.change;
    end else begin
      nxt_st.istat = st_ff.istat | lif.change;
    end
    // Level interrupt from the next status and mask, registered with them
    nxt_st.irq = |(nxt_st.istat & nxt_st.imask);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '{filt_en: WORD_RST, out_level: WORD_RST, owp: WORD_RST,
                 imask: WORD_RST, istat: WORD_RST, odrain: WORD_RST,
                 rdata: RDATA_ZERO, wp_on: 1'b0, irq: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign irq_o   = st_ff.irq;

  // Checks on the register behaviour
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // Setup writes with protection on and off
  sequence s_prot_wr(logic [31:0] a);
    wr_i && (addr_i == a) && st_ff.wp_on;
  endsequence

  sequence s_open_wr(logic [31:0] a);
    wr_i && (addr_i == a) && !st_ff.wp_on;
  endsequence

  sequence s_stat_read;
    rd_i && (addr_i == ADDR_IRQ_STAT);
  endsequence

  // Any write or read strobe aimed at one address
  sequence s_wr_to(logic [31:0] a);
    wr_i && (addr_i == a);
  endsequence

  sequence s_rd_from(logic [31:0] a);
    rd_i && (addr_i == a);
  endsequence

  // Protection must block filter enable, filter disable and open-drain enable writes, whatever the data
  a_wp_holds_setup: assert property (
    s_prot_wr(ADDR_FILT_EN) or s_prot_wr(ADDR_FILT_DIS) or s_prot_wr(ADDR_ODRAIN_EN)
    |=> $stable(st_ff.filt_en) && $stable(st_ff.odrain))
    else $error("protected write changed a setup register");

  // Protected permission writes leave the permission mask alone
  a_owp_prot_hold: assert property (
    s_prot_wr(ADDR_OWP_EN) or s_prot_wr(ADDR_OWP_DIS) |=> $stable(st_ff.owp))
    else $error("protected write changed the output permission");

  // The protection bit itself is always writable
  a_wp_reg_write: assert property (
    s_wr_to(ADDR_PROT_MODE) |=> st_ff.wp_on == $past(wdata_i[WP_ON_BIT]))
    else $error("protection mode write did not land");

  // Enable sets only the written ones, others keep their value
  a_filt_enable_sets: assert property (
    s_open_wr(ADDR_FILT_EN)
    |=> ((st_ff.filt_en & $past(wdata_i)) == $past(wdata_i)) &&
        ((st_ff.filt_en & ~$past(wdata_i)) == ($past(st_ff.filt_en) & ~$past(wdata_i))))
    else $error("filter enable write wrong");

  // Disable clears only the written ones
  a_filt_disable_clr: assert property (
    s_open_wr(ADDR_FILT_DIS)
    |=> ((st_ff.filt_en & $past(wdata_i)) == '0) &&
        ((st_ff.filt_en | $past(wdata_i)) == ($past(st_ff.filt_en) | $past(wdata_i))))
    else $error("filter disable write wrong");

  // Status readback is the live filter setting
  a_filt_stat_read: assert property (
    s_rd_from(ADDR_FILT_STAT) |=> rdata_o == $past(st_ff.filt_en))
    else $error("filter status readback wrong");

  // Set and clear apart, so the two implications never nest
  a_out_set_ones: assert property (
    s_wr_to(ADDR_OUT_SET) |=> st_ff.out_level == ($past(st_ff.out_level) | $past(wdata_i)))
    else $error("output set wrong");

  a_out_clr_zeros: assert property (
    s_wr_to(ADDR_OUT_CLR) |=> st_ff.out_level == ($past(st_ff.out_level) & ~$past(wdata_i)))
    else $error("output clear wrong");

  // Readback shows the level scheduled for the pads
  a_out_state_read: assert property (
    s_rd_from(ADDR_OUT_STATE) |=> rdata_o == $past(st_ff.out_level))
    else $error("output state readback wrong");

  // Locked lines keep their level on a direct write
  a_out_perm_gate: assert property (
    wr_i && (addr_i == ADDR_OUT_STATE)
    |=> ((st_ff.out_level ^ $past(st_ff.out_level)) & ~$past(st_ff.owp)) == '0)
    else $error("output state changed on a locked line");

  // Permitted lines take the written level
  a_out_perm_write: assert property (
    s_wr_to(ADDR_OUT_STATE)
    |=> ((st_ff.out_level ^ $past(wdata_i)) & $past(st_ff.owp)) == '0)
    else $error("output state write missed a permitted line");

  // Pin sample returns the filtered level of each line
  a_pin_sample_read: assert property (
    s_rd_from(ADDR_PIN_SAMPLE) |=> rdata_o == $past(lif.level))
    else $error("pin sample readback wrong");

  // Read data stand one cycle only, so a stale word never leaks
  a_rdata_one_cycle: assert property (
    !rd_i |=> rdata_o == '0)
    else $error("read data stood longer than one cycle");

  // Write-only registers read as zero
  a_wo_reads_zero: assert property (
    s_rd_from(ADDR_FILT_EN) |=> rdata_o == '0)
    else $error("write-only register did not read zero");

  // Mask enable sets the written ones
  a_irq_en_sets: assert property (
    s_wr_to(ADDR_IRQ_EN) |=> (st_ff.imask & $past(wdata_i)) == $past(wdata_i))
    else $error("interrupt enable left a mask bit clear");

  // Mask disable clears the written ones
  a_irq_en_dis: assert property (
    wr_i && (addr_i == ADDR_IRQ_DIS) |=> (st_ff.imask & $past(wdata_i)) == '0)
    else $error("interrupt disable left a mask bit set");

  // A back-to-back read may put new data in the second cycle
  a_mask_readback: assert property (
    rd_i && (addr_i == ADDR_IRQ_MASK)
    |=> rdata_o == $past(st_ff.imask) ##1 ($past(rd_i) || rdata_o == '0))
    else $error("mask readback wrong or not one cycle");

  // Status bits only fall on a status read
  a_stat_sticky: assert property (
    !(rd_i && (addr_i == ADDR_IRQ_STAT))
    |=> (st_ff.istat & $past(st_ff.istat | lif.change)) == $past(st_ff.istat | lif.change))
    else $error("status bit lost or missed a change");

  // A read returns the status and keeps only same-cycle changes
  a_stat_read_clr: assert property (
    s_stat_read |=> rdata_o == $past(st_ff.istat) && st_ff.istat == $past(lif.change))
    else $error("status read did not return and clear");

  // Writes to the status register change nothing
  a_stat_wr_ignored: assert property (
    s_wr_to(ADDR_IRQ_STAT) |=> st_ff.istat == $past(st_ff.istat | lif.change))
    else $error("status write changed a status bit");

  // Open-drain enable sets the written ones while unprotected
  a_odrain_en_sets: assert property (
    s_open_wr(ADDR_ODRAIN_EN) |=> (st_ff.odrain & $past(wdata_i)) == $past(wdata_i))
    else $error("open-drain enable left a line push-pull");

  // Interrupt line tracks status and mask
  a_irq_follows: assert property (
    ##1 irq_o == |(st_ff.istat & st_ff.imask))
    else $error("interrupt output disagrees with status and mask");

  // An enabled change raises the interrupt on the next edge
  a_irq_rises_change: assert property (
    (|(lif.change & st_ff.imask)) && !(wr_i && (addr_i == ADDR_IRQ_DIS)) |=> irq_o)
    else $error("enabled change did not raise the interrupt");

  // A status read with no new enabled change drops the interrupt
  a_irq_clears_read: assert property (
    rd_i && (addr_i == ADDR_IRQ_STAT) && ((lif.change & st_ff.imask) == '0) |=> !irq_o)
    else $error("status read left the interrupt raised");
endmodule : iof_line_ctrl
`default_nettype wire

// ==== logic/iof_pkg.sv ====
// iof_pkg: address map, field positions and reset values of the I/O line block.
// Assumes 32-bit aligned word accesses on a plain strobe bus.
`default_nettype none
package iof_pkg;
  // Lines per port instance, one per register bit
  localparam int unsigned LINE_COUNT = 32;
  typedef logic [LINE_COUNT-1:0] iof_word_type;

  // Register byte addresses
  localparam logic [31:0] ADDR_FILT_EN    = 32'h400E_0E20;
  localparam logic [31:0] ADDR_FILT_DIS   = 32'h400E_0E24;
  localparam logic [31:0] ADDR_FILT_STAT  = 32'h400E_0E28;
  localparam logic [31:0] ADDR_OUT_SET    = 32'h400E_0E30;
  localparam logic [31:0] ADDR_OUT_CLR    = 32'h400E_0E34;
  localparam logic [31:0] ADDR_OUT_STATE  = 32'h400E_0E38;
  localparam logic [31:0] ADDR_PIN_SAMPLE = 32'h400E_0E3C;
  localparam logic [31:0] ADDR_IRQ_EN     = 32'h400E_0E40;
  localparam logic [31:0] ADDR_IRQ_DIS    = 32'h400E_0E44;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'h400E_0E48;
  localparam logic [31:0] ADDR_IRQ_STAT   = 32'h400E_0E4C;
  localparam logic [31:0] ADDR_ODRAIN_EN  = 32'h400E_0E50;
  localparam logic [31:0] ADDR_ODRAIN_DIS = 32'h400E_0E54;
  localparam logic [31:0] ADDR_ODRAIN_ST  = 32'h400E_0E58;
  localparam logic [31:0] ADDR_OWP_EN     = 32'h400E_0EA0;
  localparam logic [31:0] ADDR_OWP_DIS    = 32'h400E_0EA4;
  localparam logic [31:0] ADDR_OWP_STAT   = 32'h400E_0EA8;
  localparam logic [31:0] ADDR_PROT_MODE  = 32'h400E_0EE4;

  // Field position of write_protect_on in protection_mode_register
  localparam int unsigned WP_ON_BIT = 0;

  // Reset values
  localparam iof_word_type WORD_RST = 32'h0000_0000;
  localparam logic [31:0]  RDATA_ZERO = 32'h0000_0000;
endpackage : iof_pkg
`default_nettype wire

// ==== logic/iof_line_if.sv ====
// iof_line_if: per-line bundle between the register core, sampler and pad driver.
// Assumes all three sit on the same core clock.
`default_nettype none
interface iof_line_if;
  iof_pkg::iof_word_type filt_en;     // Glitch filter on per line
  iof_pkg::iof_word_type level;       // Sampled, filtered pin level
  iof_pkg::iof_word_type change;      // One-cycle change pulse per line
  iof_pkg::iof_word_type out_level;   // Level scheduled for the pin
  iof_pkg::iof_word_type open_drain;  // Drive low only
  iof_pkg::iof_word_type out_en;      // Line is an output

  modport core (output filt_en, out_level, open_drain, out_en, input level, change);
  modport smp  (input filt_en, output level, change);
  modport drv  (input out_level, open_drain, out_en);
endinterface : iof_line_if
`default_nettype wire

// ==== logic/iof_pin_sampler.sv ====
// iof_pin_sampler: samples the pins, applies the glitch filter, flags changes.
// Assumes pin inputs already synchronous to core_clk_i.
`default_nettype none
module iof_pin_sampler (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire iof_pkg::iof_word_type pin_i,
  iof_line_if.smp                    lif
);
  import iof_pkg::*;

  typedef struct packed {
    iof_word_type raw;
    iof_word_type level;
    iof_word_type change;
  } iof_smp_state_type;

  iof_smp_state_type st_ff;
  iof_smp_state_type nxt_st;
  iof_word_type      nxt_level;

  // Filtered lines only follow a level seen on two samples in a row,
  // so a one-cycle glitch never reaches the level or the change flag
  for (genvar i = 0; i < LINE_COUNT; i++) begin : g_line
    assign nxt_level[i] = (lif.filt_en[i] && (pin_i[i] != st_ff.raw[i])) ?
                          st_ff.level[i] : pin_i[i];
  end

  // Sampling stops with the clock; level simply holds
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.raw    = pin_i;
    nxt_st.level  = nxt_level;
    nxt_st.change = nxt_level ^ st_ff.level;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '{raw: WORD_RST, level: WORD_RST, change: WORD_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lif.level  = st_ff.level;
  assign lif.change = st_ff.change;
endmodule : iof_pin_sampler
`default_nettype wire

// ==== logic/iof_pad_drive.sv ====
// iof_pad_drive: registers pad data and enable for each line.
// Assumes the pad merges pin_o and pin_oe_o into the real wire.
`default_nettype none
module iof_pad_drive (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  iof_line_if.drv                   lif,
  output var iof_pkg::iof_word_type pin_o,
  output var iof_pkg::iof_word_type pin_oe_o
);
  import iof_pkg::*;

  typedef struct packed {
    iof_word_type dout;
    iof_word_type doe;
  } iof_drv_state_type;

  iof_drv_state_type st_ff;
  iof_drv_state_type nxt_st;

  // Open-drain lines release the pin for a high level
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.dout = lif.out_level;
    nxt_st.doe  = lif.out_en & (~lif.open_drain | ~lif.out_level);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '{dout: WORD_RST, doe: WORD_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_o    = st_ff.dout;
  assign pin_oe_o = st_ff.doe;
endmodule : iof_pad_drive
`default_nettype wire

// ==== sim/iof_pin_model.sv ====
// iof_pin_model: the package pins as seen from outside, pull-up on each line.
// Assumes the block's pad data and enable plus a bench-controlled external load.
`default_nettype none
module iof_pin_model (
  input  wire logic                  core_clk_i,
  input  wire iof_pkg::iof_word_type pin_o_i,
  input  wire iof_pkg::iof_word_type pin_oe_i,
  input  wire iof_pkg::iof_word_type ext_en_i,
  input  wire iof_pkg::iof_word_type ext_val_i,
  output var  iof_pkg::iof_word_type pin_lvl_o
);
  import iof_pkg::*;
  iof_word_type wire_lvl;

  // Block drive wins; a released line shows the load, else the pull-up
  always_comb begin
    wire_lvl = (pin_oe_i & pin_o_i) | (~pin_oe_i & (ext_val_i | ~ext_en_i));
  end

  // Synchroniser in front of the block, so the level is clean at every edge
  always_ff @(posedge core_clk_i) begin
    pin_lvl_o <= wire_lvl;
  end
endmodule : iof_pin_model
`default_nettype wire

// ==== sim/iof_line_ctrl_tb.sv ====
// iof_line_ctrl_tb: self-checking bench for the I/O line register block.
// Assumes the strobe bus of the block and the pin model on its pad side.
`default_nettype none
module iof_line_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iof_pkg::*;

  logic         core_clk = 1'b0;
  logic         rst      = 1'b1;
  logic [31:0]  addr     = 32'h0000_0000;
  logic [31:0]  rdata;
  logic         wr       = 1'b0;
  logic         rd       = 1'b0;
  logic         irq;
  iof_word_type wdata    = 32'h0000_0000;
  iof_word_type line_oe  = 32'h0000_0000;
  iof_word_type ext_en   = 32'hFFFF_FFFF;
  iof_word_type ext_val  = 32'h0000_0000;
  iof_word_type pin_lvl;
  iof_word_type pin_o;
  iof_word_type pin_oe;
  int           fails       = 0;
  int           checks_done = 0;

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  iof_line_ctrl dut_u (.core_clk_i(core_clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .pin_i(pin_lvl),
    .line_out_en_i(line_oe), .pin_o(pin_o), .pin_oe_o(pin_oe));

  iof_pin_model pin_u (.core_clk_i(core_clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_lvl_o(pin_lvl));

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One-cycle write strobe; the register holds the value from the next edge
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask : rd_chk

  task automatic t_reset();
    rd_chk("filt_stat", ADDR_FILT_STAT, 32'h0000_0000);
    rd_chk("out_state", ADDR_OUT_STATE, 32'h0000_0000);
    rd_chk("irq_mask", ADDR_IRQ_MASK, 32'h0000_0000);
    rd_chk("irq_stat", ADDR_IRQ_STAT, 32'h0000_0000);
    chk("irq_o", {31'h0, irq}, 32'h0000_0000);
  endtask : t_reset

  task automatic t_filter();
    bus_wr(ADDR_FILT_EN, 32'h0000_00F0);
    bus_wr(ADDR_FILT_DIS, 32'h0000_0030);
    rd_chk("filt_stat", ADDR_FILT_STAT, 32'h0000_00C0);
  endtask : t_filter

  // Protected writes must leave filter and open-drain settings alone
  task automatic t_protect();
    bus_wr(ADDR_PROT_MODE, 32'h0000_0001);
    bus_wr(ADDR_FILT_EN, 32'hFF00_0000);
    bus_wr(ADDR_FILT_DIS, 32'h0000_00C0);
    bus_wr(ADDR_ODRAIN_EN, 32'h0000_0001);
    bus_wr(ADDR_OWP_EN, 32'h0000_0002);
    rd_chk("owp_stat", ADDR_OWP_STAT, 32'h0000_0000);
    rd_chk("filt_stat", ADDR_FILT_STAT, 32'h0000_00C0);
    rd_chk("odrain_st", ADDR_ODRAIN_ST, 32'h0000_0000);
    bus_wr(ADDR_PROT_MODE, 32'h0000_0000);
  endtask : t_protect

  task automatic t_output();
    bus_wr(ADDR_OUT_SET, 32'h0000_FFFF);
    bus_wr(ADDR_OUT_CLR, 32'h0000_00F0);
    rd_chk("out_state", ADDR_OUT_STATE, 32'h0000_FF0F);
    bus_wr(ADDR_OUT_STATE, 32'h0000_0000);
    rd_chk("out_state", ADDR_OUT_STATE, 32'h0000_FF0F);
    bus_wr(ADDR_OWP_EN, 32'h0000_0001);
    bus_wr(ADDR_OUT_STATE, 32'h0000_0000);
    rd_chk("out_state", ADDR_OUT_STATE, 32'h0000_FF0E);
    bus_wr(ADDR_OWP_DIS, 32'h0000_0001);
  endtask : t_output

  // Lines 5 and 7 get a one-cycle glitch; only the unfiltered line 5 counts
  task automatic t_irq();
    bus_wr(ADDR_IRQ_EN, 32'h0000_0300);
    bus_wr(ADDR_IRQ_DIS, 32'h0000_0200);
    rd_chk("irq_mask", ADDR_IRQ_MASK, 32'h0000_0100);
    @(posedge core_clk);
    ext_val <= 32'h0000_0300;
    repeat (6) @(posedge core_clk);
    #1;
    chk("irq_o", {31'h0, irq}, 32'h0000_0001);
    rd_chk("irq_stat", ADDR_IRQ_STAT, 32'h0000_0300);
    @(posedge core_clk);
    #1;
    chk("irq_o", {31'h0, irq}, 32'h0000_0000);
    rd_chk("irq_stat", ADDR_IRQ_STAT, 32'h0000_0000);
    @(posedge core_clk);
    ext_val <= 32'h0000_01A0;
    @(posedge core_clk);
    ext_val <= 32'h0000_0100;
    repeat (6) @(posedge core_clk);
    #1;
    chk("irq_o", {31'h0, irq}, 32'h0000_0000);
    rd_chk("irq_stat", ADDR_IRQ_STAT, 32'h0000_0220);
    rd_chk("pin_smp", ADDR_PIN_SAMPLE, 32'h0000_0100);
  endtask : t_irq

  // Line 0 open drain on a pull-up, line 1 push-pull
  task automatic t_drive();
    @(posedge core_clk);
    line_oe <= 32'h0000_0003;
    ext_en  <= 32'hFFFF_FFFE;
    bus_wr(ADDR_ODRAIN_EN, 32'h0000_0001);
    rd_chk("odrain_st", ADDR_ODRAIN_ST, 32'h0000_0001);
    bus_wr(ADDR_OUT_SET, 32'h0000_0003);
    repeat (3) @(posedge core_clk);
    #1;
    chk("pin_oe", pin_oe & 32'h0000_0003, 32'h0000_0002);
    chk("pin_o", pin_o & pin_oe & 32'h0000_0003, 32'h0000_0002);
    rd_chk("pin_smp", ADDR_PIN_SAMPLE, 32'h0000_0103);
    bus_wr(ADDR_OUT_CLR, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    #1;
    chk("pin_oe", pin_oe & 32'h0000_0003, 32'h0000_0003);
    chk("pin_o", pin_o & 32'h0000_0003, 32'h0000_0002);
  endtask : t_drive

  task automatic t_misc();
    rd_chk("unmapped", 32'h400E_0E2C, 32'h0000_0000);
    rd_chk("wo_read", ADDR_FILT_EN, 32'h0000_0000);
    // Lines 0 and 1 changed during the drive scenario; a write must not clear them
    bus_wr(ADDR_IRQ_STAT, 32'hFFFF_FFFF);
    rd_chk("irq_stat", ADDR_IRQ_STAT, 32'h0000_0003);
    rd_chk("irq_stat", ADDR_IRQ_STAT, 32'h0000_0000);
  endtask : t_misc

  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_filter();
    t_protect();
    t_output();
    t_irq();
    t_drive();
    t_misc();
    results();
  end

  // Watchdog, far beyond the roughly 120 cycles the scenarios need
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    results();
  end
endmodule : iof_line_ctrl_tb
`default_nettype wire
